// [logic/atp_core.sv]
// Output pattern select, offset pedestal target and control pin steering
// Operation
// - Code 000 normal data, 001 all zeros, 010 all ones, 011 toggle.
// - Code 100 ramps up one LSB; wide every clock, narrow every fourth to 4095.
// - With correction on, loop settles output at mid-code plus pedestal.
// - Six-bit pedestal field is added to the loop's settled target.
// - Pedestal is two's complement: 31 up to -32 LSB around mid-code.
// - Reset tied high turns data and enable pins into static controls.
// - Enable pin is serial enable when reset low, clock edge select when high.
`timescale 1ns/10ps
module atp_core
(
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // Variant select, high for the 12-bit converter
    input wire logic narrow_variant,
    // Control pins
    input wire logic reset_pin,
    input wire logic serial_data_in,
    input wire logic serial_enable_in,
    // Decoded register write port from the serial interface
    input wire logic reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic soft_reset,
    // Conversion and offset loop
    input wire logic [13:0] conv_data,
    input wire logic offset_corr_en,
    // Outputs
    output logic [13:0] data_out,
    output logic [13:0] offset_target,
    output logic [7:0] reg_rdata,
    output logic serial_active,
    output logic parallel_mode,
    output logic parallel_ctrl,
    output logic clkout_edge_sel
);
    logic rst_meta_q, rst_n_q;
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst) {rst_meta_q, rst_n_q} <= 2'h0;
        else {rst_meta_q, rst_n_q} <= {1'b1, rst_meta_q};
    end

    // Pin synchronisers, two stages each
    logic [2:0] pin_meta_q, pin_q;
    always_ff @(posedge clock or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            pin_meta_q <= 3'h0;
            pin_q <= 3'h0;
        end
        else
        begin
            pin_meta_q <= {reset_pin, serial_data_in, serial_enable_in};
            pin_q <= pin_meta_q;
        end
    end
    wire rst_pin_s = pin_q[2];
    wire data_pin_s = pin_q[1];
    wire en_pin_s = pin_q[0];

    // A high reset pin clears the registers on every clock while it is high, even in a short pulse;
    // held high it means parallel control, which keeps registers at default.
    wire reg_clear = rst_pin_s || soft_reset;
    wire wr_pat = reg_wr && reg_addr == atp_pkg::ADDR_PATTERN && !rst_pin_s;
    wire wr_ped = reg_wr && reg_addr == atp_pkg::ADDR_PEDESTAL && !rst_pin_s;

    logic [2:0] pat_q;
    logic [5:0] ped_q;
    always_ff @(posedge clock or negedge rst_n_q)
    begin
        if (!rst_n_q) pat_q <= atp_pkg::PAT_RST;
        else if (reg_clear) pat_q <= atp_pkg::PAT_RST;
        else if (wr_pat) pat_q <= reg_wdata[2:0];
    end
    always_ff @(posedge clock or negedge rst_n_q)
    begin
        if (!rst_n_q) ped_q <= atp_pkg::PED_RST;
        else if (reg_clear) ped_q <= atp_pkg::PED_RST;
        else if (wr_ped) ped_q <= reg_wdata[5:0];
    end

    // Toggle phase and ramp
    logic tog_q;
    logic [1:0] div_q;
    logic [13:0] ramp_q;
    wire is_ramp = pat_q == atp_pkg::PAT_RAMP;
    wire ramp_step = !narrow_variant || div_q == atp_pkg::RAMP_DIV_NARROW;
    // Variant is a strap; switching it mid-ramp above 4095 runs on to 16383 before the wrap
    wire ramp_wrap = narrow_variant && ramp_q == atp_pkg::RAMP_MAX_NARROW;
    wire [13:0] ramp_d = ramp_wrap ? atp_pkg::ALL_ZEROS : ramp_q + 14'h0001;
    always_ff @(posedge clock or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            tog_q <= 1'b0;
            div_q <= 2'h0;
            ramp_q <= 14'h0000;
        end
        else
        begin
            tog_q <= !tog_q;
            div_q <= is_ramp ? div_q + 2'h1 : 2'h0;
            if (!is_ramp) ramp_q <= 14'h0000;
            else if (ramp_step) ramp_q <= ramp_d;
        end
    end

    // Narrow variant uses the low 12 bits, upper two read as zero
    wire [13:0] width_mask = narrow_variant ? atp_pkg::RAMP_MAX_NARROW : atp_pkg::ALL_ONES;
    wire [13:0] tog_word = narrow_variant ? (atp_pkg::TOGGLE_WORD >> 2) : atp_pkg::TOGGLE_WORD;
    logic [13:0] sel_data;
    always_comb
    begin
        unique case (pat_q)
            atp_pkg::PAT_NORMAL: sel_data = conv_data;
            atp_pkg::PAT_ZEROS: sel_data = atp_pkg::ALL_ZEROS;
            atp_pkg::PAT_ONES: sel_data = atp_pkg::ALL_ONES;
            atp_pkg::PAT_TOGGLE: sel_data = tog_q ? ~tog_word : tog_word;
            atp_pkg::PAT_RAMP: sel_data = ramp_q;
            default: sel_data = conv_data;
        endcase
    end

    // Sign-extended pedestal around mid-code; 12-bit mid-code is 2048
    wire [13:0] ped_ext = {{8{ped_q[5]}}, ped_q};
    wire [13:0] mid = narrow_variant ? (atp_pkg::MID_CODE >> 2) : atp_pkg::MID_CODE;
    wire [13:0] target_d = (mid + ped_ext) & width_mask;
    wire [7:0] rdata_d = reg_addr == atp_pkg::ADDR_PATTERN ? {5'h00, pat_q}
                       : reg_addr == atp_pkg::ADDR_PEDESTAL ? {2'h0, ped_q} : 8'h00;

    always_ff @(posedge clock or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            data_out <= 14'h0000;
            offset_target <= 14'h0000;
            reg_rdata <= 8'h00;
            serial_active <= 1'b0;
            parallel_mode <= 1'b0;
            parallel_ctrl <= 1'b0;
            clkout_edge_sel <= 1'b0;
        end
        else
        begin
            data_out <= sel_data & width_mask;
            offset_target <= offset_corr_en ? target_d : offset_target;
            reg_rdata <= rdata_d;
            serial_active <= !rst_pin_s && en_pin_s;
            parallel_mode <= rst_pin_s;
            parallel_ctrl <= rst_pin_s ? data_pin_s : parallel_ctrl;
            clkout_edge_sel <= rst_pin_s ? en_pin_s : clkout_edge_sel;
        end
    end

    // Checks
    // Antecedents that read rst_n_q skip the release edge, where the outputs still show reset
    AST_ZEROS: assert property (@(posedge clock) disable iff (!rst_n_q)
        pat_q == atp_pkg::PAT_ZEROS |=> data_out == 14'h0000)
        else $error("zeros pattern wrong");
    AST_ONES: assert property (@(posedge clock) disable iff (!rst_n_q)
        pat_q == atp_pkg::PAT_ONES |=> data_out == $past(width_mask))
        else $error("ones pattern wrong");
    AST_NORMAL: assert property (@(posedge clock) disable iff (!rst_n_q)
        rst_n_q && pat_q == atp_pkg::PAT_NORMAL |=> data_out == ($past(conv_data) & $past(width_mask)))
        else $error("normal data not passed");
    AST_WR_PAT: assert property (@(posedge clock) disable iff (!rst_n_q)
        wr_pat && !reg_clear |=> pat_q == 3'($past(reg_wdata)))
        else $error("pattern write lost");
    AST_TOGGLE: assert property (@(posedge clock) disable iff (!rst_n_q)
        pat_q == atp_pkg::PAT_TOGGLE ##1 pat_q == atp_pkg::PAT_TOGGLE |=> data_out == (~$past(data_out) & width_mask))
        else $error("toggle not complementing");
    AST_TOG_WORD: assert property (@(posedge clock) disable iff (!rst_n_q)
        pat_q == atp_pkg::PAT_TOGGLE && !narrow_variant
        |=> data_out == atp_pkg::TOGGLE_WORD || data_out == ~atp_pkg::TOGGLE_WORD)
        else $error("toggle word wrong");
    AST_RAMP_WIDE: assert property (@(posedge clock) disable iff (!rst_n_q)
        is_ramp && !narrow_variant && $past(is_ramp) |-> ##1 data_out == $past(data_out) + 14'h0001)
        else $error("wide ramp not stepping");
    AST_RAMP_TOP: assert property (@(posedge clock) disable iff (!rst_n_q)
        narrow_variant |-> ramp_q <= atp_pkg::RAMP_MAX_NARROW)
        else $error("narrow ramp beyond top");
    AST_RAMP_HOLD: assert property (@(posedge clock) disable iff (!rst_n_q)
        is_ramp && narrow_variant && !ramp_step |=> ramp_q == $past(ramp_q))
        else $error("narrow ramp too fast");
    AST_RAMP_STEP_N: assert property (@(posedge clock) disable iff (!rst_n_q)
        is_ramp && narrow_variant && ramp_step && !ramp_wrap |=> ramp_q == $past(ramp_q) + 14'h0001)
        else $error("narrow ramp not stepping");
    AST_RAMP_WRAP: assert property (@(posedge clock) disable iff (!rst_n_q)
        is_ramp && ramp_wrap && ramp_step |=> ramp_q == 14'h0000)
        else $error("narrow ramp not wrapping");
    AST_TARGET: assert property (@(posedge clock) disable iff (!rst_n_q)
        rst_n_q && offset_corr_en && !narrow_variant
        |=> offset_target == 14'(atp_pkg::MID_CODE + {{8{$past(ped_q[5])}}, $past(ped_q)}))
        else $error("pedestal target wrong");
    AST_TARGET_HOLD: assert property (@(posedge clock) disable iff (!rst_n_q)
        rst_n_q && !offset_corr_en |=> offset_target == $past(offset_target))
        else $error("target moved with correction off");
    AST_WR_PED: assert property (@(posedge clock) disable iff (!rst_n_q)
        wr_ped && !reg_clear |=> ped_q == 6'($past(reg_wdata)))
        else $error("pedestal write lost");
    AST_RDATA: assert property (@(posedge clock) disable iff (!rst_n_q)
        rst_n_q && reg_addr == atp_pkg::ADDR_PEDESTAL |=> reg_rdata == {2'h0, $past(ped_q)})
        else $error("pedestal readback wrong");
    AST_CLEAR: assert property (@(posedge clock) disable iff (!rst_n_q)
        reg_clear |=> pat_q == atp_pkg::PAT_RST && ped_q == atp_pkg::PED_RST)
        else $error("clear missed");
    AST_PAR_CTRL: assert property (@(posedge clock) disable iff (!rst_n_q)
        rst_pin_s |=> parallel_ctrl == $past(data_pin_s))
        else $error("parallel control pin not followed");
    AST_PAR: assert property (@(posedge clock) disable iff (!rst_n_q)
        rst_pin_s |=> !serial_active && parallel_mode)
        else $error("serial active in parallel mode");
    AST_EDGE_SEL: assert property (@(posedge clock) disable iff (!rst_n_q)
        rst_pin_s |=> clkout_edge_sel == $past(en_pin_s))
        else $error("edge select pin not followed");
    AST_SERIAL_EN: assert property (@(posedge clock) disable iff (!rst_n_q)
        rst_n_q && !rst_pin_s |=> serial_active == $past(en_pin_s))
        else $error("serial enable not followed");
    COV_TOGGLE: cover property (@(posedge clock) pat_q == atp_pkg::PAT_TOGGLE);
    COV_RAMP_WRAP: cover property (@(posedge clock) is_ramp && ramp_wrap && ramp_step);
    COV_NEG_PED: cover property (@(posedge clock) offset_corr_en && ped_q[5]);
    COV_PARALLEL: cover property (@(posedge clock) parallel_mode && clkout_edge_sel);
endmodule : atp_core

// [logic/atp_pkg.sv]
// Package for the converter test pattern and offset pedestal block
package atp_pkg;
    localparam int DATA_W = 14;
    localparam int ADDR_W = 8;
    localparam int REG_W = 8;
    localparam int PED_W = 6;
    localparam int PAT_W = 3;
    localparam logic [7:0] ADDR_PATTERN = 8'h62;
    localparam logic [7:0] ADDR_PEDESTAL = 8'h63;
    localparam logic [2:0] PAT_RST = 3'h0;
    localparam logic [5:0] PED_RST = 6'h00;
    localparam logic [2:0] PAT_NORMAL = 3'h0;
    localparam logic [2:0] PAT_ZEROS = 3'h1;
    localparam logic [2:0] PAT_ONES = 3'h2;
    localparam logic [2:0] PAT_TOGGLE = 3'h3;
    localparam logic [2:0] PAT_RAMP = 3'h4;
    localparam logic [13:0] TOGGLE_WORD = 14'h2AAA;
    localparam logic [13:0] MID_CODE = 14'h2000;
    localparam logic [13:0] RAMP_MAX_NARROW = 14'h0FFF;
    localparam logic [1:0] RAMP_DIV_NARROW = 2'h3;
    localparam logic [13:0] ALL_ONES = 14'h3FFF;
    localparam logic [13:0] ALL_ZEROS = 14'h0000;
endpackage : atp_pkg

// [verif/atp_capture.sv]
// Capture-side model: registers the output word and keeps the one before it
`timescale 1ns/10ps
module atp_capture
(
    // Clock and captured bus
    input wire logic clock,
    input wire logic [13:0] data_in,
    output logic [13:0] word_q,
    output logic [13:0] prev_q
);
    always_ff @(posedge clock)
    begin
        word_q <= data_in;
        prev_q <= word_q;
    end
endmodule : atp_capture

// [verif/atp_core_tb.sv]
// Self-checking bench for the pattern select and pedestal block
`timescale 1ns/10ps
module atp_core_tb;
    logic clock = 0, nrst = 0, rp = 0, sd = 0, se = 0, wr_s = 0, srst = 0, oce = 1, sact, pmode, pctl, esel;
    logic nv = 0;
    logic [7:0] addr = 8'h00, wdat = 8'h00, rdat;
    logic [13:0] conv = 14'h0000, dout, tgt, cw, cp;
    logic [5:0] p;
    logic [5:0] ped_tab [4] = '{6'h1F, 6'h00, 6'h3F, 6'h20};
    int err_total = 0, compares = 0, cyc = 0, s;
    always #4 clock = ~clock;
    atp_core i_atp_core (.clock(clock), .nrst(nrst), .narrow_variant(nv), .reset_pin(rp), .serial_data_in(sd),
        .serial_enable_in(se), .reg_wr(wr_s), .reg_addr(addr), .reg_wdata(wdat), .soft_reset(srst),
        .conv_data(conv), .offset_corr_en(oce), .data_out(dout), .offset_target(tgt), .reg_rdata(rdat),
        .serial_active(sact), .parallel_mode(pmode), .parallel_ctrl(pctl), .clkout_edge_sel(esel));
    atp_capture i_atp_capture (.clock(clock), .data_in(dout), .word_q(cw), .prev_q(cp));
    task automatic end_of_test();
        $display("Compares %0d, mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_of_test
    // A hang is cut short here and reported as a mismatch
    always @(posedge clock)
        if (++cyc == 30000)
        begin
            err_total++;
            end_of_test();
        end
    task automatic chk(input string what, input logic [13:0] exp, input logic [13:0] got);
        compares++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic tick(input int n = 1);
        repeat (n) @(posedge clock);
        #1;
    endtask : tick
    // Strobe held for exactly one edge, as a decoded serial write
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr = a;
        wdat = d;
        wr_s = 1;
        tick();
        wr_s = 0;
    endtask : wr
    function automatic logic [13:0] ped_exp(input logic [5:0] v);
        return atp_pkg::MID_CODE + {{8{v[5]}}, v};
    endfunction : ped_exp
    initial
    begin
        s = $urandom(59);
        tick(16);
        nrst = 1;
        tick(4);
        for (int c = 0; c < 3; c++)
        begin
            conv = 14'($urandom);
            wr(atp_pkg::ADDR_PATTERN, 8'(c));
            tick(2);
            chk("pattern", c == 0 ? conv : c == 1 ? atp_pkg::ALL_ZEROS : atp_pkg::ALL_ONES, dout);
        end
        wr(atp_pkg::ADDR_PATTERN, {5'h00, atp_pkg::PAT_TOGGLE});
        tick(3);
        chk("toggle pair", atp_pkg::ALL_ONES, cw ^ cp);
        chk("toggle word", atp_pkg::TOGGLE_WORD, cw[13] ? cw : ~cw);
        wr(atp_pkg::ADDR_PATTERN, {5'h00, atp_pkg::PAT_RAMP});
        tick(3);
        chk("ramp start", 14'h0000, cp);
        chk("pattern readback", {11'h000, atp_pkg::PAT_RAMP}, 14'(rdat));
        repeat (4)
        begin
            chk("ramp step", cp + 14'h0001, cw);
            tick();
        end
        for (int i = 0; i < 12; i++)
        begin
            p = i >= 8 ? ped_tab[i - 8] : 6'($urandom);
            wr(atp_pkg::ADDR_PEDESTAL, {2'h0, p});
            tick(3);
            chk("loop target", ped_exp(p), tgt);
            chk("pedestal readback", {8'h00, p}, 14'(rdat));
        end
        srst = 1;
        tick();
        srst = 0;
        tick(2);
        chk("soft clear", 14'h0000, 14'(rdat));
        addr = atp_pkg::ADDR_PATTERN;
        tick(2);
        chk("soft clear pattern", 14'h0000, 14'(rdat));
        // Narrow variant: low 12 bits only, ramp steps every fourth clock and wraps after 4095
        nv = 1;
        conv = 14'($urandom) | 14'h3000;
        tick(2);
        chk("narrow normal", conv & 14'h0FFF, dout);
        wr(atp_pkg::ADDR_PATTERN, {5'h00, atp_pkg::PAT_TOGGLE});
        tick(3);
        chk("narrow toggle pair", 14'h0FFF, cw ^ cp);
        chk("narrow toggle word", 14'h0AAA, cw[11] ? cw : cp);
        wr(atp_pkg::ADDR_PATTERN, {5'h00, atp_pkg::PAT_RAMP});
        tick();
        for (int j = 0; j < 4; j++)
        begin
            chk("narrow ramp", 14'(j), dout);
            tick(4);
        end
        tick(16364);
        chk("narrow ramp top", 14'h0FFF, dout);
        tick(4);
        chk("narrow ramp wrap", 14'h0000, dout);
        wr(atp_pkg::ADDR_PEDESTAL, 8'h3F);
        tick(3);
        chk("narrow target", 14'h07FF, tgt);
        oce = 0;
        wr(atp_pkg::ADDR_PEDESTAL, 8'h01);
        tick(3);
        chk("target held", 14'h07FF, tgt);
        oce = 1;
        se = 1;
        tick(4);
        chk("serial enable", 14'h0001, 14'(sact));
        rp = 1;
        sd = 1;
        tick(6);
        wr(atp_pkg::ADDR_PATTERN, 8'h01);
        tick(2);
        chk("parallel pins", 14'h000E, {10'h000, pmode, pctl, esel, sact});
        chk("write refused", 14'h0000, 14'(rdat));
        end_of_test();
    end
endmodule : atp_core_tb
